/* File: pkg/pcv_port_regs.vh */
// Register indices, field positions and codes for the port configuration block.
// Contract
// [R1] Mask bit n puts pin n in group
// [R2] Masked write updates only selected pin controls
// [R3] Mask clears after any pin control write
// [R4] Map register A selects virtual ports 1,0
// [R5] Map register B selects virtual ports 3,2
// [R6] Virtual registers alias mapped physical registers exactly
// [R7] Map code 0..15 selects ports in order
// [R8] Alternate bit moves outputs to pin 4
// [R9] RTC enable drives RTC clock on C6
// [R10] Event port field: off, C, D, E
// [R11] Software keeps clock and event ports different
// [R12] Routed signal shown only on output pins
// [R13] Clock source: 1x, 2x, 4x, reserved
// [R14] Clock port field: off, C, D, E
// [R15] Clock wins over event on same pin
// [R16] Channel select picks one of eight events
// [R17] Software writes zero to reserved event bits
// [R18] Input reads pin levels when buffer enabled
// [R19] Matching sensed pin sets interrupt flag n
// [R20] Write one clears flag, zero keeps it
// [R21] Sense: both, rising, falling, low level
// [R22] Zero mask writes only addressed pin control
// [R23] Reset clears all configuration fields
`ifndef PCV_PORT_REGS_VH
`define PCV_PORT_REGS_VH

// ----------------------------------------------------------------------------
// Configuration register indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define PCV_IDX_MPC_MASK 12'h000
`define PCV_IDX_MAP_A 12'h002
`define PCV_IDX_MAP_B 12'h003
`define PCV_IDX_CLKEV 12'h004
`define PCV_IDX_EVENT_OUTPUT_CTRL 12'h006

// ----------------------------------------------------------------------------
// Virtual and physical windows
// ----------------------------------------------------------------------------
`define PCV_VP_BASE 12'h010
`define PCV_VP_SPAN 12'h010
`define PCV_PH_BASE 12'h100
`define PCV_VOFF_DIR 2'h0
`define PCV_VOFF_OUT 2'h1
`define PCV_VOFF_IN 2'h2
`define PCV_VOFF_FLAG 2'h3
`define PCV_POFF_DIR 5'h00
`define PCV_POFF_OUT 5'h04
`define PCV_POFF_IN 5'h08
`define PCV_POFF_MASK0 5'h0A
`define PCV_POFF_MASK1 5'h0B
`define PCV_POFF_FLAG 5'h0C
`define PCV_POFF_PCTRL 2'h2

// ----------------------------------------------------------------------------
// Fields and codes
// ----------------------------------------------------------------------------
`define PCV_CE_ALT 7
`define PCV_CE_RTC 6
`define PCV_CE_EVP 5:4
`define PCV_CE_SRC 3:2
`define PCV_CE_CKP 1:0
`define PCV_EV_SEL 2:0
`define PCV_EV_MASK 8'h07
`define PCV_PC_INV 6
`define PCV_PC_ISC 2:0
`define PCV_ISC_BOTH 3'h0
`define PCV_ISC_RISE 3'h1
`define PCV_ISC_FALL 3'h2
`define PCV_ISC_LOW 3'h3
`define PCV_ISC_OFF 3'h7
`define PCV_SRC_1X 2'h0
`define PCV_SRC_2X 2'h1
`define PCV_SRC_4X 2'h2
`define PCV_PIN_DEF 3'h7
`define PCV_PIN_ALT 3'h4
`define PCV_PIN_RTC 3'h6
`define PCV_PORT_C 4'h2
`define PCV_RST8 8'h00

`endif

/* File: logic/pcv_port_cfg.v */
// Port configuration, virtual port windows and clock/event output routing.
`default_nettype none

module pcv_port_cfg #(
  parameter NPORTS = 16
) (
  input wire ref_clk,
  input wire nrst,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  input wire [8*NPORTS-1:0] pin_in,
  input wire [7:0] event_chan,
  input wire periph_clock_base,
  input wire periph_clock_double,
  input wire periph_clock_quad,
  input wire rtc_clock,
  output reg [8*NPORTS-1:0] pin_out,
  output reg [8*NPORTS-1:0] pin_oe,
  output reg [2*NPORTS-1:0] port_irq_flag
);
`include "pcv_port_regs.vh"

  localparam K_NONE = 4'h0;
  localparam K_MPC = 4'h1;
  localparam K_MAPA = 4'h2;
  localparam K_MAPB = 4'h3;
  localparam K_CLKEV = 4'h4;
  localparam K_EVC = 4'h5;
  localparam K_DIR = 4'h6;
  localparam K_OUT = 4'h7;
  localparam K_IN = 4'h8;
  localparam K_FLAG = 4'h9;
  localparam K_MASK0 = 4'hA;
  localparam K_MASK1 = 4'hB;
  localparam K_PCTRL = 4'hC;

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  reg [7:0] multi_pin_mask_q;
  reg [7:0] virtual_map_ctrl_a_q;
  reg [7:0] virtual_map_ctrl_b_q;
  reg [7:0] clock_event_output_ctrl_q;
  reg [7:0] event_output_ctrl_q;
  reg [7:0] dir_q [0:NPORTS-1];
  reg [7:0] out_q [0:NPORTS-1];
  reg [7:0] mask0_q [0:NPORTS-1];
  reg [7:0] mask1_q [0:NPORTS-1];
  reg [7:0] in_prev_q [0:NPORTS-1];
  reg [1:0] flag_q [0:NPORTS-1];
  reg [7:0] pin_control_reg_q [0:8*NPORTS-1];
  reg [11:0] idx_q;
  reg wr_pend_q;
  reg rd_pend_q;

  // Each process owns its loop indices so that no variable has two drivers.
  integer p;
  integer n;
  integer bp;
  integer bn;
  integer fp;
  integer rp;

  // --------------------------------------------------------------------------
  // Address decode of the registered data-phase address
  // --------------------------------------------------------------------------
  reg [3:0] dk;
  reg [3:0] dp;
  reg [2:0] dn;
  reg [3:0] vsel;
  reg [11:0] vdiff;
  reg [11:0] pdiff;

  always @* begin
    dk = K_NONE;
    dp = 4'h0;
    dn = 3'h0;
    vdiff = idx_q - `PCV_VP_BASE;
    pdiff = idx_q - `PCV_PH_BASE;
    case (vdiff[3:2])
      2'h0: vsel = virtual_map_ctrl_a_q[3:0]; // [R4]
      2'h1: vsel = virtual_map_ctrl_a_q[7:4]; // [R4]
      2'h2: vsel = virtual_map_ctrl_b_q[3:0]; // [R5]
      default: vsel = virtual_map_ctrl_b_q[7:4]; // [R5]
    endcase
    if (idx_q == `PCV_IDX_MPC_MASK) begin
      dk = K_MPC;
    end else if (idx_q == `PCV_IDX_MAP_A) begin
      dk = K_MAPA;
    end else if (idx_q == `PCV_IDX_MAP_B) begin
      dk = K_MAPB;
    end else if (idx_q == `PCV_IDX_CLKEV) begin
      dk = K_CLKEV;
    end else if (idx_q == `PCV_IDX_EVENT_OUTPUT_CTRL) begin
      dk = K_EVC;
    end else if (idx_q >= `PCV_VP_BASE && vdiff < `PCV_VP_SPAN) begin
      // Code k selects physical port k in order, so the code is the index.
      dp = vsel; // [R7]
      case (vdiff[1:0])
        `PCV_VOFF_DIR: dk = K_DIR; // [R6]
        `PCV_VOFF_OUT: dk = K_OUT; // [R6]
        `PCV_VOFF_IN: dk = K_IN; // [R6]
        default: dk = K_FLAG; // [R6]
      endcase
    end else if (idx_q >= `PCV_PH_BASE && pdiff[11:9] == 3'h0) begin
      dp = pdiff[8:5];
      dn = pdiff[2:0];
      if (pdiff[4:3] == `PCV_POFF_PCTRL) begin
        dk = K_PCTRL;
      end else begin
        case (pdiff[4:0])
          `PCV_POFF_DIR: dk = K_DIR;
          `PCV_POFF_OUT: dk = K_OUT;
          `PCV_POFF_IN: dk = K_IN;
          `PCV_POFF_MASK0: dk = K_MASK0;
          `PCV_POFF_MASK1: dk = K_MASK1;
          `PCV_POFF_FLAG: dk = K_FLAG;
          default: dk = K_NONE;
        endcase
      end
    end
    // A map code naming a port that is not built reaches nothing.
    if ({28'h0, dp} >= NPORTS) begin
      dk = K_NONE;
    end
  end

  // --------------------------------------------------------------------------
  // Input conditioning and sense detection
  // --------------------------------------------------------------------------
  reg [7:0] in_eff [0:NPORTS-1];
  reg [NPORTS-1:0] set0_c;
  reg [NPORTS-1:0] set1_c;
  reg hit;
  reg [7:0] pc;

  always @* begin
    hit = 1'b0;
    pc = `PCV_RST8;
    for (p = 0; p < NPORTS; p = p + 1) begin
      set0_c[p] = 1'b0;
      set1_c[p] = 1'b0;
      for (n = 0; n < 8; n = n + 1) begin
        pc = pin_control_reg_q[p*8+n];
        // A disabled input buffer reads as zero and raises nothing.
        if (pc[`PCV_PC_ISC] == `PCV_ISC_OFF) begin
          in_eff[p][n] = 1'b0; // [R18]
        end else begin
          in_eff[p][n] = pin_in[p*8+n] ^ pc[`PCV_PC_INV]; // [R18]
        end
        case (pc[`PCV_PC_ISC])
          `PCV_ISC_BOTH: hit = in_eff[p][n] ^ in_prev_q[p][n]; // [R21]
          `PCV_ISC_RISE: hit = in_eff[p][n] & ~in_prev_q[p][n]; // [R21]
          `PCV_ISC_FALL: hit = ~in_eff[p][n] & in_prev_q[p][n]; // [R21]
          `PCV_ISC_LOW: hit = ~in_eff[p][n]; // [R21]
          default: hit = 1'b0;
        endcase
        set0_c[p] = set0_c[p] | (hit & mask0_q[p][n]); // [R19]
        set1_c[p] = set1_c[p] | (hit & mask1_q[p][n]); // [R19]
      end
    end
  end

  // --------------------------------------------------------------------------
  // Read mux
  // --------------------------------------------------------------------------
  reg [7:0] rdat_c;

  always @* begin
    case (dk)
      K_MPC: rdat_c = multi_pin_mask_q;
      K_MAPA: rdat_c = virtual_map_ctrl_a_q;
      K_MAPB: rdat_c = virtual_map_ctrl_b_q;
      K_CLKEV: rdat_c = clock_event_output_ctrl_q;
      K_EVC: rdat_c = event_output_ctrl_q & `PCV_EV_MASK;
      K_DIR: rdat_c = dir_q[dp]; // [R6]
      K_OUT: rdat_c = out_q[dp]; // [R6]
      K_IN: rdat_c = in_eff[dp]; // [R18]
      K_MASK0: rdat_c = mask0_q[dp];
      K_MASK1: rdat_c = mask1_q[dp];
      K_FLAG: rdat_c = {6'h00, flag_q[dp]}; // [R6]
      K_PCTRL: rdat_c = pin_control_reg_q[{dp, dn}];
      default: rdat_c = `PCV_RST8;
    endcase
  end

  // --------------------------------------------------------------------------
  // Bus slave and register writes
  // --------------------------------------------------------------------------
  // Reads take one wait state so that hrdata comes from a flop; writes take none.
  wire wdo = wr_pend_q;
  wire [7:0] wd = hwdata[7:0];
  wire take = hsel & htrans[1] & hready & ~rd_pend_q;

  // Address and data phase tracking.
  always @(posedge ref_clk) begin
    if (!nrst) begin
      idx_q <= 12'h000;
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      wr_pend_q <= take & hwrite;
      rd_pend_q <= take & ~hwrite;
      if (take) begin
        idx_q <= haddr[13:2];
      end
      hreadyout <= ~(take & ~hwrite);
      if (rd_pend_q) begin
        hrdata <= {24'h000000, rdat_c};
      end
      // Refused accesses read zero rather than erroring, so OKAY is the only answer.
      hresp <= 1'b0;
    end
  end

  // Configuration and port registers, written in the data phase.
  always @(posedge ref_clk) begin
    if (!nrst) begin
      multi_pin_mask_q <= `PCV_RST8; // [R23]
      virtual_map_ctrl_a_q <= `PCV_RST8; // [R23]
      virtual_map_ctrl_b_q <= `PCV_RST8; // [R23]
      clock_event_output_ctrl_q <= `PCV_RST8; // [R23]
      event_output_ctrl_q <= `PCV_RST8; // [R23]
      for (bp = 0; bp < NPORTS; bp = bp + 1) begin
        dir_q[bp] <= `PCV_RST8;
        out_q[bp] <= `PCV_RST8;
        mask0_q[bp] <= `PCV_RST8;
        mask1_q[bp] <= `PCV_RST8;
        for (bn = 0; bn < 8; bn = bn + 1) begin
          pin_control_reg_q[bp*8+bn] <= `PCV_RST8;
        end
      end
    end else if (wdo) begin
      case (dk)
        K_MPC: multi_pin_mask_q <= wd; // [R1]
        K_MAPA: virtual_map_ctrl_a_q <= wd; // [R4]
        K_MAPB: virtual_map_ctrl_b_q <= wd; // [R5]
        K_CLKEV: clock_event_output_ctrl_q <= wd;
        K_EVC: event_output_ctrl_q <= wd & `PCV_EV_MASK;
        K_DIR: dir_q[dp] <= wd; // [R6]
        K_OUT: out_q[dp] <= wd; // [R6]
        K_MASK0: mask0_q[dp] <= wd;
        K_MASK1: mask1_q[dp] <= wd;
        K_PCTRL: begin
          if (multi_pin_mask_q != `PCV_RST8) begin
            for (bn = 0; bn < 8; bn = bn + 1) begin
              if (multi_pin_mask_q[bn]) begin
                pin_control_reg_q[{dp, bn[2:0]}] <= wd; // [R1] [R2]
              end
            end
          end else begin
            pin_control_reg_q[{dp, dn}] <= wd; // [R22]
          end
          // The mask is one-shot: it never outlives the write it shaped.
          multi_pin_mask_q <= `PCV_RST8; // [R3]
        end
        default: ;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Interrupt flags
  // --------------------------------------------------------------------------
  // Write-one-to-clear strobes, one pair per port, decoded from the data phase.
  reg [2*NPORTS-1:0] clr_c;

  always @* begin
    clr_c = {2*NPORTS{1'b0}};
    if (wdo && dk == K_FLAG) begin
      clr_c[dp*2 +: 2] = wd[1:0]; // [R20]
    end
  end

  always @(posedge ref_clk) begin
    if (!nrst) begin
      for (fp = 0; fp < NPORTS; fp = fp + 1) begin
        in_prev_q[fp] <= `PCV_RST8;
        flag_q[fp] <= 2'h0;
      end
    end else begin
      for (fp = 0; fp < NPORTS; fp = fp + 1) begin
        in_prev_q[fp] <= in_eff[fp];
        // A flag raised in the cycle of its clear stays set, so no event is lost.
        flag_q[fp] <= (flag_q[fp] & ~clr_c[fp*2 +: 2]) | {set1_c[fp], set0_c[fp]}; // [R19] [R20]
      end
    end
  end

  // --------------------------------------------------------------------------
  // Clock and event output routing
  // --------------------------------------------------------------------------
  // Clock inputs are sampled on ref_clk, so a 2x or 4x source is only a level
  // here; the pad-side mux in the real chip is where true rates survive.
  reg clk_sig;
  reg ev_sig;
  reg [2:0] rpin;
  reg [3:0] pcode;
  reg [8*NPORTS-1:0] out_c;
  reg [8*NPORTS-1:0] oe_c;
  reg [2*NPORTS-1:0] flag_c;

  always @* begin
    case (clock_event_output_ctrl_q[`PCV_CE_SRC])
      `PCV_SRC_1X: clk_sig = periph_clock_base; // [R13]
      `PCV_SRC_2X: clk_sig = periph_clock_double; // [R13]
      `PCV_SRC_4X: clk_sig = periph_clock_quad; // [R13]
      default: clk_sig = 1'b0;
    endcase
    ev_sig = event_chan[event_output_ctrl_q[`PCV_EV_SEL]]; // [R16]
    rpin = clock_event_output_ctrl_q[`PCV_CE_ALT] ? `PCV_PIN_ALT : `PCV_PIN_DEF; // [R8]
    pcode = 4'h0;
    for (rp = 0; rp < NPORTS; rp = rp + 1) begin
      out_c[rp*8 +: 8] = out_q[rp];
      oe_c[rp*8 +: 8] = dir_q[rp];
      flag_c[rp*2 +: 2] = flag_q[rp];
      // Field code 1..3 names ports C..E, which sit at index code+1.
      pcode = rp[3:0] - 4'h1;
      if (dir_q[rp][rpin] && pcode[3:2] == 2'h0 && pcode[1:0] != 2'h0) begin // [R12]
        if (clock_event_output_ctrl_q[`PCV_CE_CKP] == pcode[1:0]) begin
          out_c[rp*8+rpin] = clk_sig; // [R14] [R15]
        end else if (clock_event_output_ctrl_q[`PCV_CE_EVP] == pcode[1:0]) begin
          out_c[rp*8+rpin] = ev_sig; // [R10]
        end
      end
      if (rp[3:0] == `PCV_PORT_C && clock_event_output_ctrl_q[`PCV_CE_RTC]
          && dir_q[rp][`PCV_PIN_RTC]) begin
        out_c[rp*8+`PCV_PIN_RTC] = rtc_clock; // [R9] [R12]
      end
    end
  end

  always @(posedge ref_clk) begin
    if (!nrst) begin
      pin_out <= {8*NPORTS{1'b0}};
      pin_oe <= {8*NPORTS{1'b0}};
      port_irq_flag <= {2*NPORTS{1'b0}};
    end else begin
      pin_out <= out_c;
      pin_oe <= oe_c;
      port_irq_flag <= flag_c;
    end
  end

endmodule // pcv_port_cfg

`default_nettype wire

/* File: dv/pcv_port_cfg_properties.sv */
// Concurrent checks on the port configuration block's bus and pin ports.
`default_nettype none
module pcv_cfg_props #(
  parameter NPORTS = 16
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [8*NPORTS-1:0] pin_oe,
  input wire logic [2*NPORTS-1:0] port_irq_flag
);
  timeunit 1ns;
  timeprecision 1ns;
  wire req = hsel && htrans[1] && hready;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  sequence rd_taken;
    req && !hwrite;
  endsequence
  sequence rd_answer;
    !hreadyout ##1 hreadyout;
  endsequence
  a_read_wait: assert property (rd_taken |=> rd_answer)
    else $error("read answer timing wrong");
  a_write_nowait: assert property (req && hwrite |=> hreadyout)
    else $error("write was stalled");
  a_stall_cause: assert property ($fell(hreadyout) |-> $past(req && !hwrite))
    else $error("stall without a read");
  a_resp_okay: assert property (hresp == 1'h0)
    else $error("response not okay");
  a_rdata_hold: assert property (hreadyout && $past(hreadyout) |-> $stable(hrdata))
    else $error("read data moved");
  a_upper_zero: assert property (hrdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  a_oe_cause: assert property ($changed(pin_oe) |-> $past(req && hwrite, 3))
    else $error("direction changed without a write");
  a_flag_clear: assert property (|($past(port_irq_flag) & ~port_irq_flag)
    |-> $past(req && hwrite, 3))
    else $error("flag cleared without a write");
  a_reset_zero: assert property ($rose(nrst) |-> pin_oe == '0 && port_irq_flag == '0)
    else $error("outputs not cleared by reset");
endmodule // pcv_cfg_props

bind pcv_port_cfg pcv_cfg_props #(.NPORTS(NPORTS)) chk_u (.ref_clk, .nrst, .hsel, .htrans,
  .hwrite, .hready, .hrdata, .hreadyout, .hresp, .pin_oe, .port_irq_flag);
`default_nettype wire

/* File: dv/pcv_tb.sv */
// Self-checking bench for the port configuration block.
`default_nettype none
`include "pcv_port_regs.vh"
`define CK(e, g, s) begin n_compared++; if ((g) !== (e)) begin mismatches++; \
  $display("BAD %s exp %0h got %0h", s, e, g); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'h0, nrst = 1'h0, hsel = 1'h1, hwrite = 1'h0;
  logic ck1 = 1'h0, ck2 = 1'h0, ck4 = 1'h0, rtc = 1'h1, hreadyout, hresp;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, port_irq_flag;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [127:0] pin_in = 128'h0, pin_out, pin_oe;
  logic [7:0] event_chan = 8'h00, q, v;
  integer mismatches = 0, n_compared = 0;
  initial forever #5 ref_clk = ~ref_clk;
  pcv_port_cfg #(.NPORTS(16)) dut_u (.ref_clk, .nrst, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .pin_in, .event_chan,
    .periph_clock_base(ck1), .periph_clock_double(ck2), .periph_clock_quad(ck4),
    .rtc_clock(rtc), .pin_out, .pin_oe, .port_irq_flag);
  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic cyc(input integer n);
    repeat (n) @(posedge ref_clk);
  endtask
  // Waits for hready at a rising edge; a stuck slave ends the run.
  task automatic wt;
    integer n;
    n = 0;
    @(posedge ref_clk);
    while (hreadyout !== 1'h1 && n < 20) begin
      n++;
      @(posedge ref_clk);
    end
    if (n == 20) begin
      mismatches++;
      end_of_test;
    end
  endtask
  task automatic xf(input logic w, input logic [11:0] i, input logic [7:0] d);
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {18'h0, i, 2'h0};
    wt;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    wt;
    q = hrdata[7:0];
  endtask
  task automatic wr(input logic [11:0] i, input logic [7:0] d);
    xf(1'h1, i, d);
  endtask
  task automatic rc(input logic [11:0] i, input logic [7:0] e);
    xf(1'h0, i, 8'h00);
    `CK(e, q, $sformatf("reg %0h", i))
  endtask
  function automatic logic [11:0] ph(input integer p, input integer o);
    return `PCV_PH_BASE + 12'(32 * p + o);
  endfunction
  function automatic logic [11:0] vp(input integer n, input integer o);
    return `PCV_VP_BASE + 12'(4 * n + o);
  endfunction
  task automatic t_map;
    for (int k = 0; k < 16; k++) begin
      v = 8'(k * 37 + 5);
      wr(`PCV_IDX_MAP_A, {4'(15 - k), 4'(k)});
      wr(`PCV_IDX_MAP_B, {4'(k), 4'(15 - k)});
      wr(vp(0, `PCV_VOFF_OUT), v);
      rc(ph(k, `PCV_POFF_OUT), v);
      rc(vp(3, `PCV_VOFF_OUT), v);
      wr(vp(1, `PCV_VOFF_DIR), ~v);
      rc(ph(15 - k, `PCV_POFF_DIR), ~v);
      rc(vp(2, `PCV_VOFF_DIR), ~v);
      `CK(~v, pin_oe[8 * (15 - k) +: 8], "oe")
    end
    rc(`PCV_IDX_MAP_A, 8'h0F);
  endtask
  task automatic t_mask;
    wr(`PCV_IDX_MPC_MASK, 8'h81);
    rc(`PCV_IDX_MPC_MASK, 8'h81);
    wr(ph(1, 19), 8'h01);
    rc(`PCV_IDX_MPC_MASK, 8'h00);
    wr(ph(1, 18), 8'h02);
    for (int n = 0; n < 8; n++)
      rc(ph(1, 16 + n), n == 2 ? 8'h02 : (n % 7 == 0 ? 8'h01 : 8'h00));
    rc(`PCV_IDX_MPC_MASK, 8'h00);
  endtask
  task automatic t_flag;
    pin_in[17] <= 1'h1;
    wr(`PCV_IDX_MAP_A, 8'h02);
    wr(ph(2, `PCV_POFF_MASK0), 8'h01);
    wr(ph(2, `PCV_POFF_MASK1), 8'h02);
    wr(ph(2, 16), {5'h0, `PCV_ISC_RISE});
    wr(ph(2, 17), {5'h0, `PCV_ISC_FALL});
    rc(vp(0, `PCV_VOFF_FLAG), 8'h00);
    pin_in[16] <= 1'h1;
    cyc(4);
    `CK(2'h1, port_irq_flag[5:4], "irq pins")
    rc(vp(0, `PCV_VOFF_IN), 8'h03);
    wr(vp(0, `PCV_VOFF_FLAG), 8'h00);
    rc(ph(2, `PCV_POFF_FLAG), 8'h01);
    wr(vp(0, `PCV_VOFF_FLAG), 8'h01);
    rc(ph(2, `PCV_POFF_FLAG), 8'h00);
    pin_in[17:16] <= 2'h0;
    cyc(4);
    rc(vp(0, `PCV_VOFF_FLAG), 8'h02);
    wr(ph(2, `PCV_POFF_FLAG), 8'h02);
    wr(ph(2, 16), {5'h0, `PCV_ISC_OFF});
    pin_in[16] <= 1'h1;
    cyc(4);
    rc(vp(0, `PCV_VOFF_IN), 8'h00);
    rc(vp(0, `PCV_VOFF_FLAG), 8'h00);
    wr(ph(2, 16), {5'h0, `PCV_ISC_BOTH});
    wr(ph(2, 17), {5'h0, `PCV_ISC_LOW});
    pin_in[16] <= 1'h0;
    cyc(4);
    rc(vp(0, `PCV_VOFF_FLAG), 8'h03);
  endtask
  task automatic t_route;
    for (int p = 2; p < 5; p++) begin
      wr(ph(p, `PCV_POFF_DIR), 8'hFF);
      wr(ph(p, `PCV_POFF_OUT), 8'h00);
    end
    for (int c = 1; c < 4; c++)
      for (int s = 0; s < 4; s++) begin
        ck1 <= (s == 0);
        ck2 <= (s == 1);
        ck4 <= (s == 2);
        wr(`PCV_IDX_CLKEV, 8'(s * 4 + c));
        cyc(2);
        `CK(s < 3, pin_out[8 * c + 15], "clock pin")
      end
    ck1 <= 1'h1;
    wr(`PCV_IDX_CLKEV, 8'h81);
    cyc(2);
    `CK(2'h1, {pin_out[23], pin_out[20]}, "alt pin")
    for (int ch = 0; ch < 8; ch++) begin
      event_chan <= 8'h01 << ch;
      wr(`PCV_IDX_EVENT_OUTPUT_CTRL, 8'(ch));
      wr(`PCV_IDX_CLKEV, 8'(16 * (ch % 3 + 1)));
      cyc(2);
      `CK(1'h1, pin_out[8 * (ch % 3) + 23], "event pin")
    end
    ck1 <= 1'h0;
    event_chan <= 8'hFF;
    wr(`PCV_IDX_CLKEV, 8'h11);
    cyc(2);
    `CK(1'h0, pin_out[23], "shared pin")
    ck1 <= 1'h1;
    wr(ph(2, `PCV_POFF_DIR), 8'h40);
    wr(`PCV_IDX_CLKEV, 8'h51);
    cyc(2);
    `CK(2'h1, pin_out[23:22], "rtc pin")
    wr(`PCV_IDX_EVENT_OUTPUT_CTRL, 8'hFF);
    rc(`PCV_IDX_EVENT_OUTPUT_CTRL, 8'h07);
  endtask
  // A second reset in mid-run must wipe the five configuration registers and every pin direction written earlier.
  task automatic t_reset;
    wr(`PCV_IDX_MAP_B, 8'h3C);
    wr(12'h001, 8'hFF);
    rc(12'h001, 8'h00);
    nrst <= 1'h0;
    cyc(3);
    nrst <= 1'h1;
    rc(`PCV_IDX_MPC_MASK, 8'h00);
    rc(`PCV_IDX_MAP_A, 8'h00);
    rc(`PCV_IDX_MAP_B, 8'h00);
    rc(`PCV_IDX_CLKEV, 8'h00);
    rc(`PCV_IDX_EVENT_OUTPUT_CTRL, 8'h00);
    `CK(128'h0, pin_oe, "oe")
  endtask
  initial begin
    cyc(12);
    nrst <= 1'h1;
    t_mask;
    $display("mask test done");
    t_map;
    $display("map test done");
    t_flag;
    $display("flag test done");
    t_route;
    $display("route test done");
    t_reset;
    $display("reset test done");
    end_of_test;
  end
endmodule // testbench
`default_nettype wire
